// file: core/sbm_bit_engine.sv
// Bit engine: start, stop, byte write and byte read on open-drain lines
`timescale 1ns/1ps
module sbm_bit_engine #(
   parameter int unsigned QTR = sbm_pkg::QTR_CYCLES
) (
   // Clock and reset
   input  wire logic ref_clk_in,
   input  wire logic nrst_in,
   // Sequencer side
   sbm_bit_if.eng    bus,
   // Synchronised line levels
   input  wire logic sda_s_in,
   // Line drivers, high means released
   output logic      scl_rel_out,
   output logic      sda_rel_out
);
   import sbm_pkg::*;

   logic [QTR_W-1:0] qcnt_reg;
   logic [1:0]       phase_reg;
   logic [3:0]       bit_reg;
   logic             busy_reg;
   sbm_op_e          op_reg;
   logic [8:0]       sh_reg;
   logic             tick;
   logic             last_bit;

   assign tick     = busy_reg && (qcnt_reg == QTR_W'(QTR - 1));
   assign last_bit = (op_reg == SBM_OP_WRITE || op_reg == SBM_OP_READ) ? (bit_reg == 4'h8) : 1'b1;
   assign bus.idle = !busy_reg;

   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in || !busy_reg || tick) qcnt_reg <= '0;
      else                               qcnt_reg <= qcnt_reg + 1'b1;
   end

   // Phase 0: SCL low, set SDA; 1: raise SCL; 2: SCL high, sample; 3: lower SCL
   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         busy_reg    <= 1'b0;
         phase_reg   <= 2'd0;
         bit_reg     <= 4'h0;
         op_reg      <= SBM_OP_STOP;
         sh_reg      <= '1;
         scl_rel_out <= 1'b1;
         sda_rel_out <= 1'b1;
         bus.done    <= 1'b0;
         bus.rbyte   <= 8'h00;
         bus.ack_seen<= 1'b0;
      end else begin
         bus.done <= 1'b0;
         if (!busy_reg && bus.req) begin
            busy_reg  <= 1'b1;
            phase_reg <= 2'd0;
            bit_reg   <= 4'h0;
            op_reg    <= bus.op;
            // Ninth bit is the acknowledge slot; released when reading the slave's ack [R06]
            sh_reg    <= (bus.op == SBM_OP_READ) ? {8'hff, !bus.mack} : {bus.wbyte, 1'b1};
         end else if (tick) begin
            phase_reg <= phase_reg + 2'd1;
            case (op_reg)
               SBM_OP_START, SBM_OP_RSTRT: begin
                  case (phase_reg)
                     2'd0: sda_rel_out <= 1'b1;
                     2'd1: scl_rel_out <= 1'b1;
                     2'd2: sda_rel_out <= 1'b0;   // SDA falls with SCL high [R03]
                     default: scl_rel_out <= 1'b0;
                  endcase
               end
               SBM_OP_STOP: begin
                  case (phase_reg)
                     2'd0: sda_rel_out <= 1'b0;
                     2'd1: scl_rel_out <= 1'b1;
                     2'd2: sda_rel_out <= 1'b1;   // SDA rises with SCL high [R04]
                     default: scl_rel_out <= 1'b1; // SCL left released while idle [R08]
                  endcase
               end
               default: begin
                  case (phase_reg)
                     2'd0: sda_rel_out <= sh_reg[8];   // Data changes only while SCL low [R05]
                     2'd1: scl_rel_out <= 1'b1;
                     2'd2: begin
                        sh_reg <= {sh_reg[7:0], sda_s_in};
                        if (bit_reg == 4'h8) bus.ack_seen <= !sda_s_in; // Low in ninth high phase is ack [R07]
                     end
                     default: scl_rel_out <= 1'b0;
                  endcase
               end
            endcase
            if (phase_reg == 2'd3) begin
               bit_reg <= bit_reg + 4'h1;
               if (last_bit) begin
                  busy_reg <= 1'b0;
                  bus.done <= 1'b1;
                  if (op_reg == SBM_OP_READ) bus.rbyte <= sh_reg[8:1];
               end
            end
         end
      end
   end
endmodule : sbm_bit_engine

// file: core/sbm_bit_if.sv
// Interface between the byte sequencer and the bit engine
`timescale 1ns/1ps
interface sbm_bit_if;
   import sbm_pkg::*;
   logic       req;
   sbm_op_e    op;
   logic [7:0] wbyte;
   logic       mack;
   logic       done;
   logic [7:0] rbyte;
   logic       ack_seen;
   logic       idle;
   modport seq (output req, output op, output wbyte, output mack,
                input done, input rbyte, input ack_seen, input idle);
   modport eng (input req, input op, input wbyte, input mack,
                output done, output rbyte, output ack_seen, output idle);
endinterface : sbm_bit_if

// file: core/sbm_master.sv
// Serial two-wire bus master with automatic EEPROM load after host reset
//
// How it works
// [R01] SCL and SDA are open drain: only pull low or release.
// [R02] Standard-mode master, 7-bit addressing, bit rate at most 100 kb/s.
// [R03] Every transfer opens with SDA falling while SCL is high.
// [R04] Every transfer closes with SDA rising while SCL is high.
// [R05] SDA changes only while SCL is low.
// [R06] Bytes are eight bits, each followed by one acknowledge slot.
// [R07] Receiver acknowledges by holding SDA low in the ninth high phase.
// [R08] Sole master; SCL runs near 100 kHz in cycles, released when idle.
// [R09] Multi-byte reads only by the autoloader; software does single bytes.
// [R10] Byte write: start, slave address, direction bit 0.
// [R11] Missing slave acknowledge sets the error status bit.
// [R12] Write sends index byte, then data byte MSB first, then stop.
// [R13] Byte read is the same but direction bit 1.
// [R14] Slave drives SDA on read data; master keeps SCL and acknowledges.
// [R15] After host reset release, a present bus triggers the EEPROM load.
// [R16] Autoloader addresses the EEPROM at slave address 1010000b.
// [R17] Image holds 00h at offset 00h and 20h at offset 01h.
// [R18] Offsets 02h, 03h load command bits 8, 6:5, 2:0 of functions 0, 1.
// [R19] Offsets 04h-07h load subsystem vendor id then subsystem id, low first.
// [R20] Bus is present only when SCL is pulled up externally.
// [R21] Writing the slave address register starts a transaction.
// [R22] Index goes out as word address; data register sends or captures a byte.
// [R23] Status reports read-data-valid, busy, error; holds protocol-select bit.
// [R24] Autoload ack failure stops, issues stop, keeps default register values.
`timescale 1ns/1ps
module sbm_master #(
   parameter int unsigned QTR = sbm_pkg::QTR_CYCLES
) (
   // Clock and reset
   input  wire logic  ref_clk_in,
   input  wire logic  nrst_in,
   // Two-wire pins, output enable low means driving low
   input  wire logic  scl_in,
   output logic       scl_out,
   output logic       scl_oe_n_out,
   input  wire logic  sda_in,
   output logic       sda_out,
   output logic       sda_oe_n_out,
   // Software registers
   input  wire logic  data_wr_in,
   input  wire logic [7:0] data_in,
   input  wire logic  index_wr_in,
   input  wire logic [7:0] index_in,
   input  wire logic  saddr_wr_in,
   input  wire logic [7:0] saddr_in,
   input  wire logic  ctrl_wr_in,
   input  wire logic  proto_sel_in,
   input  wire logic  err_clr_in,
   output logic [7:0] data_out,
   output logic [7:0] index_out,
   output logic [7:0] saddr_out,
   output logic       rd_valid_out,
   output logic       busy_out,
   output logic       error_out,
   output logic       proto_sel_out,
   // Loaded configuration
   output logic [15:0] cmd_f0_out,
   output logic [15:0] cmd_f1_out,
   output logic [15:0] ssvid_out,
   output logic [15:0] ssid_out,
   output logic       load_done_out
);
   import sbm_pkg::*;

   sbm_bit_if bif();

   logic       scl_s;
   logic       sda_s;
   logic       scl_rel;
   logic       sda_rel;
   sbm_state_e state_reg;
   sbm_state_e ret_reg;
   logic       auto_reg;
   logic       rnw_reg;
   logic       fail_reg;
   logic [7:0] ofs_reg;
   logic       req_reg;
   sbm_op_e    op_reg;
   logic [7:0] wbyte_reg;
   logic       mack_reg;
   logic       probe_reg;
   logic [1:0] probe_cnt_reg;

   sbm_sync u_scl_sync (
      .ref_clk_in (ref_clk_in),
      .nrst_in    (nrst_in),
      .d_in       (scl_in),
      .q_out      (scl_s)
   );

   sbm_sync u_sda_sync (
      .ref_clk_in (ref_clk_in),
      .nrst_in    (nrst_in),
      .d_in       (sda_in),
      .q_out      (sda_s)
   );

   sbm_bit_engine #(
      .QTR (QTR)
   ) u_eng (
      .ref_clk_in  (ref_clk_in),
      .nrst_in     (nrst_in),
      .bus         (bif.eng),
      .sda_s_in    (sda_s),
      .scl_rel_out (scl_rel),
      .sda_rel_out (sda_rel)
   );

   // Pins are never driven high; release lets the pullup set the level [R01]
   assign scl_out      = 1'b0;
   assign sda_out      = 1'b0;
   assign scl_oe_n_out = scl_rel;
   assign sda_oe_n_out = sda_rel;

   assign bif.req   = req_reg;
   assign bif.op    = op_reg;
   assign bif.wbyte = wbyte_reg;
   assign bif.mack  = mack_reg;

   assign busy_out = (state_reg != SBM_IDLE) || probe_reg; // [R23]

   // Sample SCL a few cycles after reset release to detect the pullup [R20]
   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         probe_reg     <= 1'b1;
         probe_cnt_reg <= 2'd0;
      end else if (probe_reg) begin
         probe_cnt_reg <= probe_cnt_reg + 2'd1;
         if (probe_cnt_reg == 2'd3) probe_reg <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) proto_sel_out <= 1'b0;
      else if (ctrl_wr_in) proto_sel_out <= proto_sel_in; // [R23]
   end

   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         index_out <= 8'h00;
         saddr_out <= 8'h00;
      end else begin
         if (index_wr_in && busy_out == 1'b0) index_out <= index_in;
         if (saddr_wr_in && busy_out == 1'b0) saddr_out <= saddr_in;
      end
   end

   // Byte sequencer; one request per engine operation, then wait for done
   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         state_reg    <= SBM_IDLE;
         ret_reg      <= SBM_IDLE;
         auto_reg     <= 1'b0;
         rnw_reg      <= 1'b0;
         fail_reg     <= 1'b0;
         ofs_reg      <= 8'h00;
         req_reg      <= 1'b0;
         op_reg       <= SBM_OP_STOP;
         wbyte_reg    <= 8'h00;
         mack_reg     <= 1'b0;
         data_out     <= 8'h00;
         rd_valid_out <= 1'b0;
         error_out    <= 1'b0;
         cmd_f0_out   <= CMD_RESET_VAL;
         cmd_f1_out   <= CMD_RESET_VAL;
         ssvid_out    <= SVID_RESET_VAL;
         ssid_out     <= SSID_RESET_VAL;
         load_done_out<= 1'b0;
      end else begin
         req_reg <= 1'b0;
         // Clear yields to a fresh error raised below in the same cycle
         if (err_clr_in) error_out <= 1'b0;
         if (data_wr_in && !busy_out) begin
            data_out     <= data_in;
            rd_valid_out <= 1'b0;
         end
         case (state_reg)
            SBM_IDLE: begin
               if (probe_reg && probe_cnt_reg == 2'd3) begin
                  if (scl_s) begin                   // [R15] [R20]
                     auto_reg  <= 1'b1;
                     rnw_reg   <= DIR_READ;
                     fail_reg  <= 1'b0;
                     ofs_reg   <= EE_START_OFFSET;
                     state_reg <= SBM_START;
                  end else begin
                     load_done_out <= 1'b1;
                  end
               end else if (!probe_reg && saddr_wr_in) begin // [R21]
                  auto_reg     <= 1'b0;           // Software gets one byte only [R09]
                  rnw_reg      <= saddr_in[0];
                  fail_reg     <= 1'b0;
                  rd_valid_out <= 1'b0;
                  state_reg    <= SBM_START;
               end
            end
            SBM_START: begin
               req_reg   <= 1'b1;
               op_reg    <= SBM_OP_START;          // [R03]
               ret_reg   <= SBM_ADDR;
               state_reg <= SBM_WAITOP;
            end
            SBM_ADDR: begin
               req_reg   <= 1'b1;
               op_reg    <= SBM_OP_WRITE;
               // Address is always sent as a write first to load the word address [R10]
               wbyte_reg <= auto_reg ? {EE_SLAVE_ADDR, DIR_WRITE} : {saddr_out[7:1], DIR_WRITE}; // [R16] [R02]
               ret_reg   <= SBM_INDEX;
               state_reg <= SBM_WAITOP;
            end
            SBM_INDEX: begin
               req_reg   <= 1'b1;
               op_reg    <= SBM_OP_WRITE;
               wbyte_reg <= auto_reg ? EE_START_OFFSET : index_out; // [R22] [R12]
               ret_reg   <= rnw_reg ? SBM_RSTRT : SBM_WDATA;
               state_reg <= SBM_WAITOP;
            end
            SBM_WDATA: begin
               req_reg   <= 1'b1;
               op_reg    <= SBM_OP_WRITE;
               wbyte_reg <= data_out;                // MSB first via engine shift [R12] [R22]
               ret_reg   <= SBM_STOP;
               state_reg <= SBM_WAITOP;
            end
            SBM_RSTRT: begin
               req_reg   <= 1'b1;
               op_reg    <= SBM_OP_RSTRT;
               ret_reg   <= SBM_RADDR;
               state_reg <= SBM_WAITOP;
            end
            SBM_RADDR: begin
               req_reg   <= 1'b1;
               op_reg    <= SBM_OP_WRITE;
               wbyte_reg <= auto_reg ? {EE_SLAVE_ADDR, DIR_READ} : {saddr_out[7:1], DIR_READ}; // [R13]
               ret_reg   <= SBM_RDATA;
               state_reg <= SBM_WAITOP;
            end
            SBM_RDATA: begin
               req_reg   <= 1'b1;
               op_reg    <= SBM_OP_READ;
               // Master acks each byte it receives except the last; the final byte before stop is left unacked
               mack_reg  <= auto_reg && (ofs_reg != EE_LAST_OFFSET); // [R14]
               ret_reg   <= (auto_reg && ofs_reg != EE_LAST_OFFSET) ? SBM_RDATA : SBM_STOP; // [R09]
               state_reg <= SBM_WAITOP;
            end
            SBM_STOP: begin
               req_reg   <= 1'b1;
               op_reg    <= SBM_OP_STOP;           // [R04]
               ret_reg   <= SBM_IDLE;
               state_reg <= SBM_WAITOP;
            end
            SBM_WAITOP: begin
               if (bif.done) begin
                  if (op_reg == SBM_OP_STOP) begin
                     state_reg <= SBM_IDLE;
                     if (auto_reg) load_done_out <= 1'b1;
                  end else if (op_reg == SBM_OP_WRITE && !bif.ack_seen) begin
                     error_out <= 1'b1;            // [R11]
                     fail_reg  <= 1'b1;
                     state_reg <= SBM_STOP;        // [R24]
                  end else if (op_reg == SBM_OP_READ) begin
                     if (auto_reg) begin
                        ofs_reg <= ofs_reg + 8'h01;
                        if (ofs_reg == EE_OFS_CMD0)    cmd_f0_out     <= sbm_cmd_from_byte(bif.rbyte); // [R18]
                        if (ofs_reg == EE_OFS_CMD1)    cmd_f1_out     <= sbm_cmd_from_byte(bif.rbyte);
                        if (ofs_reg == EE_OFS_SVID_LO) ssvid_out[7:0] <= bif.rbyte; // [R19]
                        if (ofs_reg == EE_OFS_SVID_HI) ssvid_out[15:8]<= bif.rbyte;
                        if (ofs_reg == EE_OFS_SSID_LO) ssid_out[7:0]  <= bif.rbyte;
                        if (ofs_reg == EE_OFS_SSID_HI) ssid_out[15:8] <= bif.rbyte;
                        // Image header is checked but a mismatch does not abort [R17]
                        if ((ofs_reg == 8'h00 && bif.rbyte != EE_FUNC_IND) ||
                            (ofs_reg == 8'h01 && bif.rbyte != EE_BYTE_COUNT)) error_out <= 1'b1;
                     end else begin
                        data_out     <= bif.rbyte; // [R22]
                        rd_valid_out <= 1'b1;
                     end
                     state_reg <= ret_reg;
                  end else begin
                     state_reg <= ret_reg;
                  end
               end
            end
            default: state_reg <= SBM_IDLE;
         endcase
      end
   end
endmodule : sbm_master

// file: core/sbm_pkg.sv
// Package with constants and types for the serial bus master with EEPROM autoload
package sbm_pkg;
   localparam int unsigned CLK_HZ          = 100_000_000;
   localparam int unsigned SCL_MAX_HZ      = 100_000;
   // Four quarter phases per bit; rounding up keeps the rate at or below the limit
   localparam int unsigned QTR_CYCLES      = (CLK_HZ + 4 * SCL_MAX_HZ - 1) / (4 * SCL_MAX_HZ);
   localparam int unsigned QTR_W           = 8;
   localparam logic [6:0]  EE_SLAVE_ADDR   = 7'h50;
   localparam logic [7:0]  EE_FUNC_IND     = 8'h00;
   localparam logic [7:0]  EE_BYTE_COUNT   = 8'h20;
   localparam logic [7:0]  EE_LAST_OFFSET  = 8'h07;
   localparam logic [7:0]  EE_OFS_CMD0     = 8'h02;
   localparam logic [7:0]  EE_OFS_CMD1     = 8'h03;
   localparam logic [7:0]  EE_OFS_SVID_LO  = 8'h04;
   localparam logic [7:0]  EE_OFS_SVID_HI  = 8'h05;
   localparam logic [7:0]  EE_OFS_SSID_LO  = 8'h06;
   localparam logic [7:0]  EE_OFS_SSID_HI  = 8'h07;
   localparam logic [7:0]  EE_START_OFFSET = 8'h00;
   localparam logic        DIR_WRITE       = 1'b0;
   localparam logic        DIR_READ        = 1'b1;
   localparam logic [15:0] CMD_RESET_VAL   = 16'h0000;
   localparam logic [15:0] SVID_RESET_VAL  = 16'h0000;
   localparam logic [15:0] SSID_RESET_VAL  = 16'h0000;

   // Bit-level operations handed to the bit engine
   typedef enum logic [2:0] {
      SBM_OP_START = 3'b000,
      SBM_OP_STOP  = 3'b001,
      SBM_OP_WRITE = 3'b010,
      SBM_OP_READ  = 3'b011,
      SBM_OP_RSTRT = 3'b100
   } sbm_op_e;

   typedef enum logic [3:0] {
      SBM_IDLE    = 4'b0000,
      SBM_START   = 4'b0001,
      SBM_ADDR    = 4'b0010,
      SBM_INDEX   = 4'b0011,
      SBM_RSTRT   = 4'b0100,
      SBM_RADDR   = 4'b0101,
      SBM_WDATA   = 4'b0110,
      SBM_RDATA   = 4'b0111,
      SBM_STOP    = 4'b1000,
      SBM_WAITOP  = 4'b1001
   } sbm_state_e;

   // Map an image byte onto the command register bits it loads
   function automatic logic [15:0] sbm_cmd_from_byte(input logic [7:0] b);
      logic [15:0] c;
      c      = 16'h0000;
      c[8]   = b[7];
      c[6:5] = b[6:5];
      c[2:0] = b[2:0];
      return c;
   endfunction : sbm_cmd_from_byte
endpackage : sbm_pkg

// file: core/sbm_sync.sv
// Two flip-flop synchroniser for a pin level
`timescale 1ns/1ps
module sbm_sync (
   // Clock and reset
   input  wire logic ref_clk_in,
   input  wire logic nrst_in,
   // Level
   input  wire logic d_in,
   output logic      q_out
);
   logic meta_reg;

   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         meta_reg <= 1'b1;
         q_out    <= 1'b1;
      end else begin
         meta_reg <= d_in;
         q_out    <= meta_reg;
      end
   end
endmodule : sbm_sync

// file: testbench/sbm_ee_model.sv
// Behavioural serial EEPROM slave answering at the loader address
`timescale 1ns/1ps
module sbm_ee_model (
   // Resolved lines
   input  wire logic scl_in,
   input  wire logic sda_in,
   // Refuses every address byte while high
   input  wire logic nack_in,
   // Data driver, high means released
   output logic      sda_rel_out
);
   logic [7:0] mem [0:255];
   logic [7:0] sh, ptr;
   int         cnt, st;
   logic       tx;
   initial begin
      sda_rel_out = 1'b1;
      st = 3;
      cnt = 0;
      tx = 1'b0;
      ptr = 8'h00;
   end
   // Data falling with the clock high opens a frame; rising closes it
   always @(negedge sda_in) if (scl_in === 1'b1) begin
      cnt = 0;
      st = 0;
      tx = 1'b0;
   end
   always @(posedge sda_in) if (scl_in === 1'b1) st = 3;
   always @(posedge scl_in) begin
      if (cnt < 8 && !tx)
         sh = {sh[6:0], sda_in};
      if (cnt == 8 && tx && sda_in) begin
         tx = 1'b0;
         st = 3;
      end
      cnt = cnt + 1;
   end
   // Only pulls low or releases, and only just after the clock falls
   always @(negedge scl_in) begin
      sda_rel_out = 1'b1;
      if (cnt == 9) begin
         cnt = 0;
         if (tx) begin
            sh = mem[ptr];
            ptr = ptr + 8'h01;
         end
      end
      if (st != 3 && tx && cnt < 8)
         sda_rel_out = sh[7 - cnt];
      else if (st != 3 && !tx && cnt == 8) begin
         sda_rel_out = 1'b0;
         if (st == 0 && (sh[7:1] != 7'h50 || nack_in)) begin
            sda_rel_out = 1'b1;
            st = 3;
         end else if (st == 0) begin
            tx = sh[0];
            st = 1;
         end else if (st == 1) begin
            ptr = sh;
            st = 2;
         end else begin
            mem[ptr] = sh;
            ptr = ptr + 8'h01;
         end
      end
   end
endmodule : sbm_ee_model

// file: testbench/sbm_master_bench.sv
// Self-checking bench for the serial bus master with EEPROM load
`timescale 1ns/1ps
module sbm_master_bench;
   import sbm_pkg::*;
   localparam int unsigned QTR = 4;
   logic        ref_clk_in, nrst_in, scl_in, sda_in, scl_pu, nack, ee_rel;
   logic        data_wr_in, index_wr_in, saddr_wr_in, ctrl_wr_in, proto_sel_in, err_clr_in;
   logic [7:0]  data_in, index_in, saddr_in, data_out, index_out, saddr_out;
   logic        scl_out, scl_oe_n_out, sda_out, sda_oe_n_out, load_done_out;
   logic        rd_valid_out, busy_out, error_out, proto_sel_out;
   logic [15:0] cmd_f0_out, cmd_f1_out, ssvid_out, ssid_out;
   int          miscompares, comparisons, cycles;
   // Released lines float to their pull-ups; SCL has none when the bus is absent
   assign scl_in = scl_oe_n_out ? scl_pu : scl_out;
   assign sda_in = (sda_oe_n_out ? 1'b1 : sda_out) & ee_rel;
   sbm_master #(.QTR(QTR)) DUT (.ref_clk_in, .nrst_in, .scl_in, .scl_out, .scl_oe_n_out, .sda_in, .sda_out,
      .sda_oe_n_out, .data_wr_in, .data_in, .index_wr_in, .index_in, .saddr_wr_in, .saddr_in, .ctrl_wr_in,
      .proto_sel_in, .err_clr_in, .data_out, .index_out, .saddr_out, .rd_valid_out, .busy_out, .error_out,
      .proto_sel_out, .cmd_f0_out, .cmd_f1_out, .ssvid_out, .ssid_out, .load_done_out);
   sbm_ee_model EE (.scl_in(scl_in), .sda_in(sda_in), .nack_in(nack), .sda_rel_out(ee_rel));
   always #5 ref_clk_in = ~ref_clk_in;
   task automatic test_done();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : test_done
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
         miscompares++;
      end
   endtask : chk
   task automatic wait_idle();
      int n;
      n = 0;
      @(negedge ref_clk_in);
      while (busy_out !== 1'b0 && n < 8000) begin
         @(negedge ref_clk_in);
         n++;
      end
      chk("busy", 16'h0000, 16'(busy_out));
   endtask : wait_idle
   task automatic do_reset(input logic pu);
      @(posedge ref_clk_in);
      nrst_in <= 1'b0;
      scl_pu <= pu;
      repeat (12) @(posedge ref_clk_in);
      nrst_in <= 1'b1;
      wait_idle();
   endtask : do_reset
   // A late index write lands while busy and must be dropped
   task automatic sw_xfer(input logic [7:0] idx, input logic [7:0] dat, input logic [7:0] sa);
      @(posedge ref_clk_in);
      index_in <= idx;
      index_wr_in <= 1'b1;
      @(posedge ref_clk_in);
      index_wr_in <= 1'b0;
      data_in <= dat;
      data_wr_in <= 1'b1;
      @(posedge ref_clk_in);
      data_wr_in <= 1'b0;
      saddr_in <= sa;
      saddr_wr_in <= 1'b1;
      @(posedge ref_clk_in);
      saddr_wr_in <= 1'b0;
      index_in <= 8'hff;
      index_wr_in <= 1'b1;
      @(posedge ref_clk_in);
      index_wr_in <= 1'b0;
      wait_idle();
      chk("index", 16'(idx), 16'(index_out));
      chk("saddr", 16'(sa), 16'(saddr_out));
   endtask : sw_xfer
   always @(posedge ref_clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         miscompares++;
         test_done();
      end
   end
   initial begin
      {ref_clk_in, nrst_in, scl_pu, nack, data_wr_in, index_wr_in, saddr_wr_in} = '0;
      {ctrl_wr_in, proto_sel_in, err_clr_in, data_in, index_in, saddr_in} = '0;
      for (int i = 0; i < 256; i++)
         EE.mem[i] = 8'h00;
      EE.mem[1] = 8'h20;
      {EE.mem[2], EE.mem[3], EE.mem[4], EE.mem[5]} = {8'ha7, 8'he4, 8'h34, 8'h12};
      {EE.mem[6], EE.mem[7]} = {8'h78, 8'h56};
      do_reset(1'b0);
      chk("load_done", 16'h0001, 16'(load_done_out));
      chk("ssvid", SVID_RESET_VAL, ssvid_out);
      do_reset(1'b1);
      chk("cmd_f0", 16'h0127, cmd_f0_out);
      chk("cmd_f1", 16'h0164, cmd_f1_out);
      chk("ssvid", 16'h1234, ssvid_out);
      chk("ssid", 16'h5678, ssid_out);
      chk("error", 16'h0000, 16'(error_out));
      sw_xfer(8'h10, 8'h5a, {7'h50, 1'b0});
      chk("ee_mem", 16'h005a, 16'(EE.mem[16]));
      sw_xfer(8'h10, 8'h00, {7'h50, 1'b1});
      chk("data", 16'h005a, 16'(data_out));
      chk("rd_valid", 16'h0001, 16'(rd_valid_out));
      chk("ee_ptr", 16'h0011, 16'(EE.ptr));
      nack <= 1'b1;
      sw_xfer(8'h00, 8'h00, {7'h50, 1'b0});
      chk("error", 16'h0001, 16'(error_out));
      @(posedge ref_clk_in);
      err_clr_in <= 1'b1;
      ctrl_wr_in <= 1'b1;
      proto_sel_in <= 1'b1;
      @(posedge ref_clk_in);
      {err_clr_in, ctrl_wr_in} <= 2'b00;
      @(negedge ref_clk_in);
      chk("error", 16'h0000, 16'(error_out));
      chk("proto", 16'h0001, 16'(proto_sel_out));
      do_reset(1'b1);
      chk("error", 16'h0001, 16'(error_out));
      chk("ssvid", SVID_RESET_VAL, ssvid_out);
      chk("load_done", 16'h0001, 16'(load_done_out));
      test_done();
   end
endmodule : sbm_master_bench
bind sbm_master sbm_master_chk #(.QTR(QTR)) u_chk (.ref_clk_in, .nrst_in, .scl_out, .scl_oe_n_out, .sda_out,
   .sda_oe_n_out, .saddr_wr_in, .index_wr_in, .ctrl_wr_in, .proto_sel_in, .err_clr_in, .index_out, .saddr_out,
   .rd_valid_out, .busy_out, .error_out, .proto_sel_out);

// file: testbench/sbm_master_chk.sv
// Pin and status checker for the serial bus master
`timescale 1ns/1ps
module sbm_master_chk #(
   parameter int unsigned QTR = 4
) (
   // Clock and reset
   input wire logic       ref_clk_in,
   input wire logic       nrst_in,
   // Pins
   input wire logic       scl_out,
   input wire logic       scl_oe_n_out,
   input wire logic       sda_out,
   input wire logic       sda_oe_n_out,
   // Software side
   input wire logic       saddr_wr_in,
   input wire logic       index_wr_in,
   input wire logic       ctrl_wr_in,
   input wire logic       proto_sel_in,
   input wire logic       err_clr_in,
   input wire logic [7:0] index_out,
   input wire logic [7:0] saddr_out,
   input wire logic       rd_valid_out,
   input wire logic       busy_out,
   input wire logic       error_out,
   input wire logic       proto_sel_out
);
   localparam int QMAX = 4 * QTR + 2;
   localparam int PER  = 4 * QTR;
   logic        scl_q_reg;
   logic [15:0] per_reg;
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!nrst_in);
   // Cycles since last SCL release; saturates so idle gaps never trip the check
   always_ff @(posedge ref_clk_in) begin
      scl_q_reg <= scl_oe_n_out;
      if (!nrst_in)
         per_reg <= 16'hffff;
      else if (scl_oe_n_out && !scl_q_reg)
         per_reg <= 16'h0001;
      else if (per_reg != 16'hffff)
         per_reg <= per_reg + 16'h0001;
   end
   property p_odrain; scl_out == 1'b0 && sda_out == 1'b0; endproperty
   a_odrain: assert property (p_odrain) else $error("pin driven high");
   property p_start; $fell(sda_oe_n_out) && scl_oe_n_out |-> ##[1:QMAX] !scl_oe_n_out; endproperty
   a_start: assert property (p_start) else $error("no clock after start");
   property p_stop; $rose(sda_oe_n_out) && scl_oe_n_out |=> scl_oe_n_out [*4]; endproperty
   a_stop: assert property (p_stop) else $error("clock moved after stop");
   property p_rate; scl_oe_n_out && !scl_q_reg |-> per_reg >= PER; endproperty
   a_rate: assert property (p_rate) else $error("clock period too short");
   property p_idle; !busy_out && !$past(busy_out) |-> scl_oe_n_out && sda_oe_n_out; endproperty
   a_idle: assert property (p_idle) else $error("line held while idle");
   property p_swstart; saddr_wr_in && !busy_out |=> busy_out ##[0:QMAX] !sda_oe_n_out; endproperty
   a_swstart: assert property (p_swstart) else $error("no transaction after address write");
   property p_refuse; busy_out && index_wr_in |=> $stable(index_out); endproperty
   a_refuse: assert property (p_refuse) else $error("index changed while busy");
   property p_rdvalid; $rose(rd_valid_out) |-> saddr_out[0] && busy_out; endproperty
   a_rdvalid: assert property (p_rdvalid) else $error("read valid without read");
   property p_errclr; err_clr_in && !busy_out |=> !error_out; endproperty
   a_errclr: assert property (p_errclr) else $error("error not cleared");
   property p_proto; ctrl_wr_in |=> proto_sel_out == $past(proto_sel_in); endproperty
   a_proto: assert property (p_proto) else $error("select not stored");
endmodule : sbm_master_chk
